//--- hw/fabric_axi_master.sv
// Purpose: fabric-side AXI master that drives the DDR fabric port
// Assumes: port logic shares sys_clk; one burst in flight at a time
// Notes: illegal commands are refused, never issued
`timescale 1ns/100ps
`include "axi_port_params.svh"
module fabric_axi_master
   import axi_port_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [`ADDR_W-1:0] cmd_addr,
   input wire logic [`LEN_W-1:0] cmd_len,
   input wire logic [1:0] cmd_burst,
   input wire logic [1:0] cmd_lock,
   input wire logic [`TAG_W-1:0] cmd_tag,
   output logic cmd_reject,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [`DATA_W-1:0] wr_data,
   input wire logic [`STRB_W-1:0] wr_strb,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [`DATA_W-1:0] rd_data,
   output logic [`TAG_W-1:0] rd_tag,
   output logic [1:0] rd_resp,
   output logic rd_last,
   output logic done_valid,
   input wire logic done_ready,
   output logic [`TAG_W-1:0] done_tag,
   output logic [1:0] done_resp,
   output logic axi_port_raddr_valid,
   input wire logic axi_port_raddr_ready,
   output logic [`ADDR_W-1:0] axi_port_read_addr,
   output logic [`TAG_W-1:0] axi_port_read_tag,
   output logic [`LEN_W-1:0] axi_port_read_len,
   output logic [1:0] axi_port_read_size,
   output logic [1:0] axi_port_read_burst,
   output logic [1:0] axi_port_read_lock,
   output logic axi_port_waddr_valid,
   input wire logic axi_port_waddr_ready,
   output logic [`ADDR_W-1:0] axi_port_write_addr,
   output logic [`TAG_W-1:0] axi_port_write_tag,
   output logic [`LEN_W-1:0] axi_port_write_len,
   output logic [1:0] axi_port_write_size,
   output logic [1:0] axi_port_write_burst,
   output logic [1:0] axi_port_write_lock,
   output logic axi_port_wdata_valid,
   input wire logic axi_port_wdata_ready,
   output logic [`DATA_W-1:0] axi_port_write_data,
   output logic [`STRB_W-1:0] axi_port_byte_strobe,
   output logic [`TAG_W-1:0] axi_port_wdata_tag,
   output logic axi_port_write_last,
   input wire logic axi_port_resp_valid,
   output logic axi_port_resp_ready,
   input wire logic [`TAG_W-1:0] axi_port_resp_tag,
   input wire logic [1:0] axi_port_resp_code,
   input wire logic axi_port_rdata_valid,
   output logic axi_port_rdata_ready,
   input wire logic [`DATA_W-1:0] axi_port_read_data,
   input wire logic [`TAG_W-1:0] axi_port_rdata_tag,
   input wire logic [1:0] axi_port_rdata_resp,
   input wire logic axi_port_rdata_last
);
   localparam int RW = `DATA_W + `TAG_W + 2 + 1;
   ctl_t s_r;
   ctl_t s_nxt;
   logic cmd_ok;
   logic wr_take;
   logic r_beat;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [RW-1:0] buf_out;
   logic [`LEN_W-1:0] len_p1;

   // command screening
   req_check u_check (
      .addr(cmd_addr),
      .len(cmd_len),
      .burst(cmd_burst),
      .lock(cmd_lock),
      .ok(cmd_ok)
   );

   // read data path with back-pressure
   pair_buffer #(
      .W(RW),
      .D(`RBUF_DEPTH)
   ) u_rbuf (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data({axi_port_read_data, axi_port_rdata_tag, axi_port_rdata_resp,
         axi_port_rdata_last}),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(buf_out)
   );
   assign rd_data = buf_out[RW-1 -: `DATA_W];
   assign rd_tag = buf_out[`TAG_W+2:3];
   assign rd_resp = buf_out[2:1];
   assign rd_last = buf_out[0];

   // handshakes
   assign cmd_ready = (s_r.st == ST_IDLE);
   assign cmd_reject = s_r.rej;
   assign axi_port_raddr_valid = (s_r.st == ST_RADDR);
   assign axi_port_waddr_valid = (s_r.st == ST_WADDR);
   assign axi_port_wdata_valid = s_r.wv;
   assign axi_port_resp_ready = (s_r.st == ST_WRESP);
   assign axi_port_rdata_ready = (s_r.st == ST_RDATA) && buf_in_ready;
   assign buf_in_valid = (s_r.st == ST_RDATA) && axi_port_rdata_valid;
   assign r_beat = axi_port_rdata_valid && axi_port_rdata_ready;
   assign wr_take = (s_r.st == ST_WDATA) && !(s_r.wv && s_r.wl)
      && (!s_r.wv || axi_port_wdata_ready);
   assign wr_ready = wr_take;
   assign done_valid = (s_r.st == ST_WDONE);
   assign done_tag = s_r.bid;
   assign done_resp = s_r.bresp;
   assign len_p1 = `LEN_W'(s_r.len + 4'h1);

   // request fields, from registers except the constant size code
   assign axi_port_read_addr = s_r.addr;
   assign axi_port_read_tag = s_r.tag;
   assign axi_port_read_len = s_r.len;
   assign axi_port_read_size = `SIZE_8B;
   assign axi_port_read_burst = s_r.burst;
   assign axi_port_read_lock = s_r.lock;
   assign axi_port_write_addr = s_r.addr;
   assign axi_port_write_tag = s_r.tag;
   assign axi_port_write_len = s_r.len;
   assign axi_port_write_size = `SIZE_8B;
   assign axi_port_write_burst = s_r.burst;
   assign axi_port_write_lock = s_r.lock;
   assign axi_port_write_data = s_r.wd;
   assign axi_port_byte_strobe = s_r.ws;
   assign axi_port_wdata_tag = s_r.tag;
   assign axi_port_write_last = s_r.wl;

   always_comb begin
      s_nxt = s_r;
      s_nxt.rej = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            if (cmd_valid) begin
               if (cmd_ok) begin
                  s_nxt.addr = cmd_addr;
                  s_nxt.len = cmd_len;
                  s_nxt.tag = cmd_tag;
                  s_nxt.burst = cmd_burst;
                  s_nxt.lock = cmd_lock;
                  s_nxt.cnt = '0;
                  s_nxt.st = cmd_write ? ST_WADDR : ST_RADDR;
               end else begin
                  s_nxt.rej = 1'b1;
               end
            end
         end
         ST_RADDR: begin
            if (axi_port_raddr_ready) begin
               s_nxt.st = ST_RDATA;
            end
         end
         ST_RDATA: begin
            if (r_beat) begin
               s_nxt.cnt = `LEN_W'(s_r.cnt + 4'h1);
               if (axi_port_rdata_last) begin
                  s_nxt.st = ST_IDLE;
               end
            end
         end
         ST_WADDR: begin
            if (axi_port_waddr_ready) begin
               s_nxt.st = ST_WDATA;
            end
         end
         ST_WDATA: begin
            if (s_r.wv && axi_port_wdata_ready) begin
               s_nxt.wv = 1'b0;
               s_nxt.wl = 1'b0;
               if (s_r.wl) begin
                  s_nxt.st = ST_WRESP;
               end
            end
            if (wr_take && wr_valid) begin
               s_nxt.wv = 1'b1;
               s_nxt.wd = wr_data;
               s_nxt.ws = wr_strb;
               s_nxt.wl = (s_r.cnt == s_r.len);
               s_nxt.cnt = `LEN_W'(s_r.cnt + 4'h1);
            end
         end
         ST_WRESP: begin
            if (axi_port_resp_valid) begin
               s_nxt.bresp = axi_port_resp_code;
               s_nxt.bid = axi_port_resp_tag;
               s_nxt.st = ST_WDONE;
            end
         end
         ST_WDONE: begin
            if (done_ready) begin
               s_nxt.st = ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   raddr_hold_a: assert property (
      axi_port_raddr_valid && !axi_port_raddr_ready |=> axi_port_raddr_valid
         && $stable(axi_port_read_addr) && $stable(axi_port_read_len))
      else $error("read address dropped before accepted");

   waddr_hold_a: assert property (
      axi_port_waddr_valid && !axi_port_waddr_ready |=> axi_port_waddr_valid
         && $stable(axi_port_write_addr) && $stable(axi_port_write_len))
      else $error("write address dropped before accepted");

   wdata_hold_a: assert property (
      axi_port_wdata_valid && !axi_port_wdata_ready |=> axi_port_wdata_valid
         && $stable(axi_port_write_data) && $stable(axi_port_write_last))
      else $error("write beat changed before accepted");

   wlast_place_a: assert property (
      axi_port_wdata_valid |-> (axi_port_write_last == (s_r.cnt == len_p1)))
      else $error("write last not on final beat");

   write_beats_a: assert property (
      axi_port_wdata_valid && axi_port_wdata_ready && axi_port_write_last
         |=> s_r.st == ST_WRESP && s_r.cnt == len_p1 && !axi_port_wdata_valid)
      else $error("write burst beat count wrong");

   size_code_a: assert property (
      axi_port_raddr_valid || axi_port_waddr_valid
         |-> axi_port_read_size == `SIZE_8B && axi_port_write_size == `SIZE_8B)
      else $error("size code not eight bytes");

   burst_code_a: assert property (
      axi_port_raddr_valid || axi_port_waddr_valid
         |-> s_r.burst == `BURST_INCR || s_r.burst == `BURST_WRAP)
      else $error("fixed or reserved burst issued");

   lock_code_a: assert property (
      axi_port_raddr_valid || axi_port_waddr_valid |-> s_r.lock != `LOCK_RSVD)
      else $error("reserved lock code issued");

   addr_align_a: assert property (
      axi_port_raddr_valid || axi_port_waddr_valid |-> s_r.addr[2:0] == 3'h0)
      else $error("unaligned start address issued");

   wdata_tag_a: assert property (
      axi_port_wdata_valid |-> axi_port_wdata_tag == axi_port_write_tag)
      else $error("write data tag differs from address tag");

   resp_ready_a: assert property (
      axi_port_resp_valid && axi_port_resp_ready |=> !axi_port_resp_ready && done_valid
         && done_tag == $past(axi_port_resp_tag) && done_resp == $past(axi_port_resp_code))
      else $error("write response not taken once");

   tag_capture_a: assert property (
      cmd_valid && cmd_ready && cmd_ok |=> axi_port_read_tag == $past(cmd_tag)
         && axi_port_wdata_tag == $past(cmd_tag) && axi_port_read_len == $past(cmd_len))
      else $error("command tag not carried to port");

   rdata_room_a: assert property (
      axi_port_rdata_ready |-> buf_in_ready && s_r.st == ST_RDATA)
      else $error("read data taken without buffer room");

   reject_a: assert property (
      cmd_valid && cmd_ready && !cmd_ok |=> cmd_reject && s_r.st == ST_IDLE
         ##1 (!cmd_reject || $past(cmd_valid && cmd_ready && !cmd_ok)))
      else $error("bad command not refused");
endmodule

//--- shared/axi_port_params.svh
// Purpose: constants for the fabric AXI master that drives the DDR port
// Assumes: 64-bit data, 8-byte beats only
// Notes: codes follow the port's signal encodings
`ifndef AXI_PORT_PARAMS_SVH
`define AXI_PORT_PARAMS_SVH
`define ADDR_W 32
`define DATA_W 64
`define STRB_W 8
`define TAG_W 4
`define LEN_W 4
`define ALIGN_MASK 3'h7
`define SIZE_8B 2'h3
`define BURST_FIXED 2'h0
`define BURST_INCR 2'h1
`define BURST_WRAP 2'h2
`define BURST_RSVD 2'h3
`define LOCK_NORMAL 2'h0
`define LOCK_EXCL 2'h1
`define LOCK_LOCKED 2'h2
`define LOCK_RSVD 2'h3
`define RESP_OKAY 2'h0
`define RESP_EXOKAY 2'h1
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`define RBUF_DEPTH 2
`endif

//--- shared/axi_port_pkg.sv
// Purpose: types for the fabric AXI master
// Assumes: constants from axi_port_params.svh
// Notes: whole controller state is one packed struct
`include "axi_port_params.svh"
package axi_port_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RADDR, ST_RDATA, ST_WADDR, ST_WDATA, ST_WRESP, ST_WDONE
   } st_t;
   typedef struct packed {
      st_t st;
      logic [`ADDR_W-1:0] addr;
      logic [`LEN_W-1:0] len;
      logic [`TAG_W-1:0] tag;
      logic [1:0] burst;
      logic [1:0] lock;
      logic [`LEN_W-1:0] cnt;
      logic wv;
      logic [`DATA_W-1:0] wd;
      logic [`STRB_W-1:0] ws;
      logic wl;
      logic [1:0] bresp;
      logic [`TAG_W-1:0] bid;
      logic rej;
   } ctl_t;
endpackage

//--- hw/req_check.sv
// Purpose: screens a user command before it reaches the port
// Assumes: combinational, same clock as the caller
// Notes: wrapping bursts must be 2, 4, 8 or 16 beats
`timescale 1ns/100ps
`include "axi_port_params.svh"
module req_check (
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`LEN_W-1:0] len,
   input wire logic [1:0] burst,
   input wire logic [1:0] lock,
   output logic ok
);
   logic burst_ok;
   logic wrap_ok;
   logic lock_ok;
   logic align_ok;
   always_comb begin
      burst_ok = (burst == `BURST_INCR) || (burst == `BURST_WRAP);
      wrap_ok = (burst != `BURST_WRAP) || (len == 4'h1) || (len == 4'h3)
         || (len == 4'h7) || (len == 4'hF);
      lock_ok = (lock != `LOCK_RSVD);
      align_ok = ((addr[2:0] & `ALIGN_MASK) == 3'h0);
      ok = burst_ok && wrap_ok && lock_ok && align_ok;
   end
endmodule

//--- hw/pair_buffer.sv
// Purpose: small FIFO between the read data channel and the user
// Assumes: depth at least two
// Notes: in_ready falls only when every entry is taken
`timescale 1ns/100ps
module pair_buffer #(
   parameter int W = 8,
   parameter int D = 2
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_r [D];
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic [CW-1:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != CW'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == PW'(D - 1)) ? '0 : PW'(wp_r + 1'b1);
         end
         if (pop) begin
            rp_r <= (rp_r == PW'(D - 1)) ? '0 : PW'(rp_r + 1'b1);
         end
         if (push && !pop) begin
            cnt_r <= CW'(cnt_r + 1'b1);
         end else if (pop && !push) begin
            cnt_r <= CW'(cnt_r - 1'b1);
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule

//--- verification/ddr_port_model.sv
// Purpose: behavioural model of the DDR fabric port, slave side
// Assumes: 64-entry memory, one burst at a time, stall slows every channel but the write response
// Notes: viol counts requests that break the master's side
`timescale 1ns/100ps
`include "axi_port_params.svh"
module ddr_port_model (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic stall,
   output logic [7:0] viol,
   input wire logic axi_port_raddr_valid,
   output logic axi_port_raddr_ready,
   input wire logic [31:0] axi_port_read_addr,
   input wire logic [3:0] axi_port_read_tag,
   input wire logic [3:0] axi_port_read_len,
   input wire logic [1:0] axi_port_read_size,
   input wire logic [1:0] axi_port_read_burst,
   input wire logic [1:0] axi_port_read_lock,
   input wire logic axi_port_waddr_valid,
   output logic axi_port_waddr_ready,
   input wire logic [31:0] axi_port_write_addr,
   input wire logic [3:0] axi_port_write_tag,
   input wire logic [3:0] axi_port_write_len,
   input wire logic [1:0] axi_port_write_size,
   input wire logic [1:0] axi_port_write_burst,
   input wire logic [1:0] axi_port_write_lock,
   input wire logic axi_port_wdata_valid,
   output logic axi_port_wdata_ready,
   input wire logic [63:0] axi_port_write_data,
   input wire logic [7:0] axi_port_byte_strobe,
   input wire logic [3:0] axi_port_wdata_tag,
   input wire logic axi_port_write_last,
   output logic axi_port_resp_valid,
   input wire logic axi_port_resp_ready,
   output logic [3:0] axi_port_resp_tag,
   output logic [1:0] axi_port_resp_code,
   output logic axi_port_rdata_valid,
   input wire logic axi_port_rdata_ready,
   output logic [63:0] axi_port_read_data,
   output logic [3:0] axi_port_rdata_tag,
   output logic [1:0] axi_port_rdata_resp,
   output logic axi_port_rdata_last
);
   logic [63:0] mem [0:63];
   logic [31:0] a;
   logic [3:0] n, l, id;
   logic [1:0] bt, rc;
   logic rd, wr;
   function automatic logic [31:0] step(input logic [31:0] x, input logic [1:0] b,
      input logic [3:0] ln);
      logic [31:0] m;
      m = (b == `BURST_WRAP) ? {25'h0, ln, 3'h7} : 32'hFFFFFFFF;
      return (x & ~m) | ((x + 32'h8) & m);
   endfunction
   function automatic logic [1:0] code(input logic [1:0] sz, input logic [1:0] b,
      input logic [1:0] lk);
      if (sz != `SIZE_8B || b == `BURST_FIXED || b == `BURST_RSVD) return `RESP_SLVERR;
      return (lk == `LOCK_EXCL) ? `RESP_EXOKAY : `RESP_OKAY;
   endfunction
   assign axi_port_raddr_ready = !stall && !rd && !wr && !axi_port_resp_valid;
   assign axi_port_waddr_ready = axi_port_raddr_ready;
   assign axi_port_wdata_ready = wr && !stall;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rd <= 1'b0;
         wr <= 1'b0;
         viol <= 8'h0;
         axi_port_rdata_valid <= 1'b0;
         axi_port_resp_valid <= 1'b0;
         for (int i = 0; i < 64; i++) mem[i] <= 64'h0;
      end else begin
         if (axi_port_raddr_valid && axi_port_raddr_ready) begin
            rd <= 1'b1;
            a <= axi_port_read_addr;
            n <= axi_port_read_len;
            l <= axi_port_read_len;
            bt <= axi_port_read_burst;
            id <= axi_port_read_tag;
            rc <= code(axi_port_read_size, axi_port_read_burst, axi_port_read_lock);
            if (axi_port_read_addr[2:0] != 3'h0 || axi_port_read_lock == `LOCK_RSVD) viol <= viol + 8'h1;
         end
         if (rd && !axi_port_rdata_valid && !stall) begin
            axi_port_rdata_valid <= 1'b1;
            axi_port_read_data <= mem[a[8:3]];
            axi_port_rdata_tag <= id;
            axi_port_rdata_resp <= rc;
            axi_port_rdata_last <= (n == 4'h0);
         end
         if (axi_port_rdata_valid && axi_port_rdata_ready) begin
            axi_port_rdata_valid <= 1'b0;
            axi_port_read_data <= ~axi_port_read_data;
            a <= step(a, bt, l);
            n <= n - 4'h1;
            if (axi_port_rdata_last) rd <= 1'b0;
         end
         if (axi_port_waddr_valid && axi_port_waddr_ready) begin
            wr <= 1'b1;
            a <= axi_port_write_addr;
            n <= axi_port_write_len;
            l <= axi_port_write_len;
            bt <= axi_port_write_burst;
            id <= axi_port_write_tag;
            rc <= code(axi_port_write_size, axi_port_write_burst, axi_port_write_lock);
            if (axi_port_write_addr[2:0] != 3'h0 || axi_port_write_lock == `LOCK_RSVD) viol <= viol + 8'h1;
         end
         if (axi_port_wdata_valid && axi_port_wdata_ready) begin
            for (int i = 0; i < 8; i++) begin
               if (axi_port_byte_strobe[i]) mem[a[8:3]][i*8 +: 8] <= axi_port_write_data[i*8 +: 8];
            end
            a <= step(a, bt, l);
            n <= n - 4'h1;
            if (axi_port_write_last != (n == 4'h0) || axi_port_wdata_tag != id) viol <= viol + 8'h1;
            if (axi_port_write_last) begin
               wr <= 1'b0;
               axi_port_resp_valid <= 1'b1;
               axi_port_resp_tag <= id;
               axi_port_resp_code <= rc;
            end
         end
         if (axi_port_resp_valid && axi_port_resp_ready) begin
            axi_port_resp_valid <= 1'b0;
            axi_port_resp_tag <= ~axi_port_resp_tag;
         end
      end
   end
endmodule

//--- verification/fabric_axi_master_bench.sv
// Purpose: self-checking bench for the fabric AXI master
// Assumes: port model answers with random stalls
// Notes: shadow memory mirrors the model for read-back
`timescale 1ns/100ps
`include "axi_port_params.svh"
module fabric_axi_master_bench;
   import axi_port_pkg::*;
   logic sys_clk = 0, reset_n = 0, stall = 0, hold = 0;
   logic cmd_valid = 0, cmd_write = 0, wr_valid = 0, rd_ready = 0, done_ready = 0;
   logic [31:0] cmd_addr = 0, seed = 32'd31511, bg, r;
   logic [3:0] cmd_len = 0, cmd_tag = 0;
   logic [1:0] cmd_burst = 0, cmd_lock = 0;
   logic [63:0] wr_data = 0, rd_data, axi_port_write_data, axi_port_read_data;
   logic [7:0] wr_strb = 0, viol, axi_port_byte_strobe;
   logic cmd_ready, cmd_reject, wr_ready, rd_valid, rd_last, done_valid;
   logic axi_port_raddr_valid, axi_port_raddr_ready, axi_port_waddr_valid;
   logic axi_port_waddr_ready, axi_port_wdata_valid, axi_port_wdata_ready;
   logic axi_port_write_last, axi_port_resp_valid, axi_port_resp_ready;
   logic axi_port_rdata_valid, axi_port_rdata_ready, axi_port_rdata_last;
   logic [31:0] axi_port_read_addr, axi_port_write_addr;
   logic [3:0] rd_tag, done_tag, axi_port_read_tag, axi_port_read_len, axi_port_write_tag;
   logic [3:0] axi_port_write_len, axi_port_wdata_tag, axi_port_resp_tag, axi_port_rdata_tag;
   logic [1:0] rd_resp, done_resp, axi_port_read_size, axi_port_read_burst;
   logic [1:0] axi_port_read_lock, axi_port_write_size, axi_port_write_burst;
   logic [1:0] axi_port_write_lock, axi_port_resp_code, axi_port_rdata_resp;
   logic [63:0] shadow [0:63];
   logic [70:0] exp_r [$];
   logic [5:0] exp_d [$];
   int failures = 0, compares = 0, cyc = 0;
   fabric_axi_master dut (.*);
   ddr_port_model model (.*);
   always #50 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] nxt(input logic [31:0] x, input logic [1:0] b,
      input logic [3:0] ln);
      logic [31:0] m;
      m = (b == `BURST_WRAP) ? {25'h0, ln, 3'h7} : 32'hFFFFFFFF;
      return (x & ~m) | ((x + 32'h8) & m);
   endfunction
   function automatic logic [1:0] rsp(input logic [1:0] lk);
      return (lk == `LOCK_EXCL) ? `RESP_EXOKAY : `RESP_OKAY;
   endfunction
   task automatic chk(input logic [70:0] seen, input logic [70:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wt(input int k);
      int n;
      n = 0;
      @(negedge sys_clk);
      while ((k == 0 ? cmd_ready : wr_ready) !== 1'b1 && n < 300) begin
         n++;
         @(negedge sys_clk);
      end
      if (n >= 300) chk(1, 0);
   endtask
   task automatic run(input logic w, input logic [31:0] ad, input logic [3:0] ln,
      input logic [1:0] b, input logic [1:0] lk, input logic [3:0] tg);
      logic [31:0] a;
      logic [63:0] d;
      logic [7:0] s;
      logic ok;
      ok = ad[2:0] == 3'h0 && lk != `LOCK_RSVD && (b == `BURST_INCR
         || (b == `BURST_WRAP && ln inside {4'h1, 4'h3, 4'h7, 4'hF}));
      a = ad;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= ad;
      cmd_len <= ln;
      cmd_burst <= b;
      cmd_lock <= lk;
      cmd_tag <= tg;
      wt(0);
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(negedge sys_clk);
      chk({cmd_reject, axi_port_raddr_valid | axi_port_waddr_valid}, {!ok, ok});
      @(posedge sys_clk);
      if (ok && w) begin
         exp_d.push_back({tg, rsp(lk)});
         for (int i = 0; i <= ln; i++) begin
            d = {xs(), xs()};
            s = 8'(xs());
            wr_valid <= 1'b1;
            wr_data <= d;
            wr_strb <= s;
            for (int k = 0; k < 8; k++) if (s[k]) shadow[a[8:3]][k*8 +: 8] = d[k*8 +: 8];
            a = nxt(a, b, ln);
            wt(1);
            @(posedge sys_clk);
         end
         wr_valid <= 1'b0;
         wr_data <= ~d;
      end else if (ok) begin
         for (int i = 0; i <= ln; i++) begin
            exp_r.push_back({i == ln, tg, rsp(lk), shadow[a[8:3]]});
            a = nxt(a, b, ln);
         end
      end
      wt(0);
   endtask
   always @(posedge sys_clk) begin
      bg = xs();
      stall <= bg[0] & bg[1];
      rd_ready <= !hold & (bg[2] | bg[3]);
      done_ready <= bg[4] | bg[5];
      cyc++;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   always @(negedge sys_clk) begin
      if (rd_valid && rd_ready) chk({rd_last, rd_tag, rd_resp, rd_data}, exp_r.pop_front());
      if (done_valid && done_ready) chk({done_tag, done_resp}, exp_d.pop_front());
   end
   initial begin
      for (int i = 0; i < 64; i++) shadow[i] = 64'h0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(negedge sys_clk);
      chk({cmd_ready, axi_port_raddr_valid, axi_port_waddr_valid, cmd_reject}, 4'h8);
      for (int lk = 0; lk < 3; lk++) begin
         run(1'b1, 32'h1F8, 4'hF, `BURST_INCR, 2'(lk), 4'(lk + 1));
         run(1'b0, 32'h1F8, 4'h0, `BURST_INCR, 2'(lk), 4'(lk + 9));
      end
      for (int k = 0; k < 4; k++) begin
         run(1'b1, 32'h88, 4'hF >> k, `BURST_WRAP, `LOCK_NORMAL, 4'h5);
         run(1'b0, 32'h80, 4'hF, `BURST_INCR, `LOCK_NORMAL, 4'h6);
      end
      run(1'b1, 32'h84, 4'h1, `BURST_INCR, `LOCK_NORMAL, 4'h2);
      run(1'b0, 32'h84, 4'h1, `BURST_INCR, `LOCK_NORMAL, 4'h2);
      run(1'b1, 32'h80, 4'h1, `BURST_FIXED, `LOCK_NORMAL, 4'h2);
      run(1'b0, 32'h80, 4'h1, `BURST_RSVD, `LOCK_NORMAL, 4'h2);
      run(1'b1, 32'h80, 4'h1, `BURST_INCR, `LOCK_RSVD, 4'h2);
      run(1'b0, 32'h80, 4'h2, `BURST_WRAP, `LOCK_NORMAL, 4'h2);
      hold = 1'b1;
      fork
         run(1'b0, 32'h0, 4'hF, `BURST_INCR, `LOCK_NORMAL, 4'hC);
         begin
            repeat (40) @(negedge sys_clk);
            chk({rd_valid, axi_port_rdata_ready}, 2'b10);
            hold = 1'b0;
         end
      join
      for (int i = 0; i < 40; i++) begin
         r = xs();
         run(r[0], {23'h0, r[9:4], 3'h0}, r[1] ? 4'hF >> r[11:10] : r[15:12],
            r[1] ? `BURST_WRAP : `BURST_INCR, r[17:16] == 2'h3 ? 2'h0 : r[17:16], r[21:18]);
      end
      repeat (20) @(negedge sys_clk);
      chk(viol, 0);
      chk(exp_r.size() + exp_d.size(), 0);
      tally_and_finish();
   end
endmodule
